// [dsc_defs.svh]
// Register map, field positions, reset values and timing counts of the switch decoder
`ifndef DSC_DEFS_SVH
`define DSC_DEFS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define DSC_ADDR_W 8
`define DSC_OFS_CTRL 8'h00
`define DSC_OFS_CMD 8'h04
`define DSC_OFS_STATUS 8'h08
`define DSC_OFS_SWITCH 8'h0c

// ****************************************
// Field positions
// ****************************************
`define DSC_CTRL_ENCMD_BIT 0
`define DSC_CTRL_COMBINE_BIT 1
`define DSC_CTRL_NODE_LSB 4
`define DSC_CMD_TRIM_BIT 0
`define DSC_CMD_RESTORE_BIT 1
`define DSC_CMD_RELATCH_BIT 2

// ****************************************
// Reset and special values
// ****************************************
`define DSC_NODE_SETTING_RST 4'h1
`define DSC_NODE_FROM_SETTING 4'h0
`define DSC_NODE_INVALID 4'hf
`define DSC_CTRL_ENCMD_RST 1'b0
`define DSC_CTRL_COMBINE_RST 1'b0

// ****************************************
// Timing
// ****************************************
`define DSC_CLK_MHZ 100
`define DSC_SAMPLE_MS 100
`define DSC_SAMPLE_CYCLES (`DSC_SAMPLE_MS * 1000 * `DSC_CLK_MHZ)
`define DSC_SETTLE_CYCLES 2'h3

`endif

// [dsc_pkg.sv]
// Types shared by the switch decoder modules
package dsc_pkg;

	// ****************************************
	// Sequencing phase
	// ****************************************
	typedef enum logic [1:0] {
		DSC_PH_BOOT = 2'b01,
		DSC_PH_RUN = 2'b10
	} dsc_phase_t;

	// ****************************************
	// Decoded switch block, switch 10 down to switch 5, then the node with switch 1 as its MSB
	// ****************************************
	typedef struct packed {
		logic sel_rs485;
		logic keypad;
		logic enable;
		logic offset;
		logic term;
		logic hold;
		logic [3:0] node;
	} dsc_sw_t;

	// ****************************************
	// Status word layout
	// ****************************************
	typedef struct packed {
		logic [16:0] zero;
		logic factory_done;
		logic node_invalid;
		logic drive_en;
		logic ext_enable;
		logic enable;
		logic term;
		logic hold;
		logic autorun_sup;
		logic keypad;
		logic sel_rs485;
		logic from_setting;
		logic [3:0] node;
	} dsc_status_t;

	// ****************************************
	// Whole state of the decoder
	// ****************************************
	typedef struct packed {
		dsc_phase_t phase;
		logic [1:0] settle;
		logic [31:0] timer;
		dsc_sw_t boot_sw;
		dsc_sw_t smp;
		logic ext_prev;
		logic [3:0] node_setting;
		logic enable_cmd;
		logic combine_mode;
		logic comb_cmd;
		logic factory_done;
		logic autorun_sup;
		logic tune_pulse;
		logic restore_all;
		logic restore_keep;
		logic drive_en;
		logic [31:0] rdata;
		logic slverr;
	} dsc_state_t;

endpackage

// [dsc_sync.sv]
// Two-stage synchroniser for a group of slow inputs
`timescale 1ns/100ps
module dsc_sync #(
	parameter int unsigned WIDTH = 11
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Data
	input wire logic [WIDTH-1:0] d_in,
	output logic [WIDTH-1:0] q_out
);

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
	} dsc_sync_state_t;

	dsc_sync_state_t state_reg;
	dsc_sync_state_t state_next;

	initial begin
		if (WIDTH < 1) $error("dsc_sync needs at least one bit");
	end

	// First stage feeds only the second
	always_comb begin
		state_next.s1 = d_in;
		state_next.s2 = state_reg.s1;
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign q_out = state_reg.s2;

endmodule

// [dsc_config_decoder.sv]
// Front-panel configuration switch decoder with APB register access
//
// Local design decisions: the register addresses and the APB register port.
`include "dsc_defs.svh"
`timescale 1ns/100ps
module dsc_config_decoder
	import dsc_pkg::*;
#(
	parameter int unsigned SAMPLE_CYCLES = `DSC_SAMPLE_CYCLES
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// APB slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [`DSC_ADDR_W-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// Operator switches, bit n-1 is switch n, high means On
	input wire logic [9:0] config_switch_block_in,
	// External drive enable input, already in active-high sense
	input wire logic ext_enable_in,
	// Startup configuration
	output logic [3:0] node_address_out,
	output logic node_from_setting_out,
	output logic link_rs485_out,
	output logic keypad_select_out,
	output logic autorun_suppress_out,
	// Run-time controls
	output logic hold_out,
	output logic terminator_out,
	output logic drive_enable_out,
	// Event strobes
	output logic offset_trim_start_out,
	output logic restore_all_out,
	output logic restore_keep_link_out
);

	// ****************************************
	// Elaboration checks
	// ****************************************
	initial begin
		if (SAMPLE_CYCLES < 2) $error("SAMPLE_CYCLES must be at least 2");
	end

	// ****************************************
	// Synchronised inputs
	// ****************************************
	logic [10:0] sync_q;
	dsc_sw_t sw_s;
	logic ext_s;

	dsc_sync #(
		.WIDTH(11)
	) u_sync (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.d_in({ext_enable_in, config_switch_block_in}),
		.q_out(sync_q)
	);

	// Switch 1 carries weight 8, so the node bits are reversed
	function automatic dsc_sw_t dsc_decode(input logic [9:0] raw);
		dsc_sw_t d;
		d.sel_rs485 = raw[9];
		d.keypad = raw[8];
		d.enable = raw[7];
		d.offset = raw[6];
		d.term = raw[5];
		d.hold = raw[4];
		d.node = {raw[0], raw[1], raw[2], raw[3]};
		return d;
	endfunction

	assign sw_s = dsc_decode(sync_q[9:0]);
	assign ext_s = sync_q[10];

	// ****************************************
	// State
	// ****************************************
	dsc_state_t state_reg;
	dsc_state_t state_next;

	localparam dsc_state_t DSC_STATE_RST = '{
		phase: DSC_PH_BOOT,
		settle: 2'h0,
		timer: 32'h0,
		boot_sw: '0,
		smp: '0,
		ext_prev: 1'b0,
		node_setting: `DSC_NODE_SETTING_RST,
		enable_cmd: `DSC_CTRL_ENCMD_RST,
		combine_mode: `DSC_CTRL_COMBINE_RST,
		comb_cmd: 1'b0,
		factory_done: 1'b0,
		autorun_sup: 1'b0,
		tune_pulse: 1'b0,
		restore_all: 1'b0,
		restore_keep: 1'b0,
		drive_en: 1'b0,
		rdata: 32'h0,
		slverr: 1'b0
	};

	// ****************************************
	// Bus decode
	// ****************************************
	logic bus_setup;
	logic bus_write;
	logic addr_ctrl;
	logic addr_cmd;
	logic addr_status;
	logic addr_switch;
	logic addr_ok;

	assign bus_setup = psel_in & ~penable_in;
	assign bus_write = psel_in & penable_in & pwrite_in;
	assign addr_ctrl = (paddr_in == `DSC_OFS_CTRL);
	assign addr_cmd = (paddr_in == `DSC_OFS_CMD);
	assign addr_status = (paddr_in == `DSC_OFS_STATUS);
	assign addr_switch = (paddr_in == `DSC_OFS_SWITCH);
	assign addr_ok = addr_ctrl | addr_cmd | addr_status | addr_switch;

	// ****************************************
	// Derived views of the state
	// ****************************************
	logic from_setting;
	logic [3:0] node_eff;
	dsc_status_t status;

	assign from_setting = (state_reg.boot_sw.node == `DSC_NODE_FROM_SETTING);
	assign node_eff = from_setting ? state_reg.node_setting : state_reg.boot_sw.node;

	always_comb begin
		status = '0;
		status.factory_done = state_reg.factory_done;
		status.node_invalid = (state_reg.boot_sw.node == `DSC_NODE_INVALID);
		status.drive_en = state_reg.drive_en;
		status.ext_enable = ext_s;
		status.enable = state_reg.smp.enable;
		status.term = state_reg.smp.term;
		status.hold = state_reg.smp.hold;
		status.autorun_sup = state_reg.autorun_sup;
		status.keypad = state_reg.boot_sw.keypad;
		status.sel_rs485 = state_reg.boot_sw.sel_rs485;
		status.from_setting = from_setting;
		status.node = node_eff;
	end

	// ****************************************
	// Next-state logic
	// ****************************************
	logic tick;
	logic sw_enable_rise;
	logic ext_rise;
	logic enable_cmd_eff;

	always_comb begin
		state_next = state_reg;
		state_next.tune_pulse = 1'b0;
		state_next.restore_all = 1'b0;
		state_next.restore_keep = 1'b0;
		tick = 1'b0;
		sw_enable_rise = 1'b0;
		ext_rise = 1'b0;
		enable_cmd_eff = 1'b0;

		unique case (state_reg.phase)
			DSC_PH_BOOT: begin
				// Wait until the synchroniser holds real switch levels
				state_next.drive_en = 1'b0;
				state_next.comb_cmd = 1'b0;
				state_next.settle = state_reg.settle + 2'h1;
				if (state_reg.settle == `DSC_SETTLE_CYCLES) begin
					state_next.boot_sw = sw_s;
					state_next.smp = sw_s;
					state_next.timer = 32'h0;
					state_next.ext_prev = ext_s;
					state_next.phase = DSC_PH_RUN;
					if ((sw_s.node == `DSC_NODE_INVALID) && !sw_s.enable) begin
						state_next.restore_all = 1'b1;
						state_next.factory_done = 1'b1;
						state_next.node_setting = `DSC_NODE_SETTING_RST;
						state_next.enable_cmd = `DSC_CTRL_ENCMD_RST;
						state_next.combine_mode = `DSC_CTRL_COMBINE_RST;
					end
					state_next.autorun_sup = sw_s.hold & sw_s.keypad & ~sw_s.enable;
				end
			end
			DSC_PH_RUN: begin
				// Run-time switches change only on the sample tick
				if (state_reg.timer == 32'(SAMPLE_CYCLES - 1)) begin
					tick = 1'b1;
					state_next.timer = 32'h0;
				end else begin
					state_next.timer = state_reg.timer + 32'h1;
				end
				if (tick) begin
					state_next.smp = sw_s;
					if (sw_s.offset && state_reg.smp.enable && !sw_s.enable) begin
						state_next.tune_pulse = 1'b1;
					end
					sw_enable_rise = sw_s.enable & ~state_reg.smp.enable;
				end
				ext_rise = ext_s & ~state_reg.ext_prev;
				state_next.ext_prev = ext_s;
				// One side already active, the other rises
				if (!(state_next.smp.enable && ext_s)) begin
					state_next.comb_cmd = 1'b0;
				end else if (sw_enable_rise || ext_rise) begin
					state_next.comb_cmd = 1'b1;
				end
				enable_cmd_eff = state_reg.combine_mode ? state_next.comb_cmd
					: state_reg.enable_cmd;
				state_next.drive_en = state_next.smp.enable & ext_s & enable_cmd_eff;
			end
			default: begin
				state_next = DSC_STATE_RST;
			end
		endcase

		// Register writes take effect in the access phase
		if (bus_write && addr_ctrl) begin
			state_next.enable_cmd = pwdata_in[`DSC_CTRL_ENCMD_BIT];
			state_next.combine_mode = pwdata_in[`DSC_CTRL_COMBINE_BIT];
			state_next.node_setting = pwdata_in[`DSC_CTRL_NODE_LSB +: 4];
		end
		if (bus_write && addr_cmd) begin
			if (pwdata_in[`DSC_CMD_TRIM_BIT]) begin
				state_next.tune_pulse = 1'b1;
			end
			if (pwdata_in[`DSC_CMD_RESTORE_BIT]) begin
				state_next.restore_keep = 1'b1;
				state_next.enable_cmd = `DSC_CTRL_ENCMD_RST;
				state_next.combine_mode = `DSC_CTRL_COMBINE_RST;
			end
			// Processor reset re-reads the startup switches
			if (pwdata_in[`DSC_CMD_RELATCH_BIT]) begin
				state_next.phase = DSC_PH_BOOT;
				state_next.settle = 2'h0;
				state_next.factory_done = 1'b0;
				state_next.drive_en = 1'b0;
			end
		end

		// Read data is prepared in the setup cycle
		if (bus_setup) begin
			state_next.slverr = ~addr_ok;
			if (addr_ctrl) begin
				state_next.rdata = 32'h0;
				state_next.rdata[`DSC_CTRL_ENCMD_BIT] = state_reg.enable_cmd;
				state_next.rdata[`DSC_CTRL_COMBINE_BIT] = state_reg.combine_mode;
				state_next.rdata[`DSC_CTRL_NODE_LSB +: 4] = state_reg.node_setting;
			end else if (addr_status) begin
				state_next.rdata = status;
			end else if (addr_switch) begin
				state_next.rdata = {22'h0, sync_q[9:0]};
			end else begin
				state_next.rdata = 32'h0;
			end
		end
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_reg <= DSC_STATE_RST;
		end else begin
			state_reg <= state_next;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// Zero wait states keep the bus timing fixed
	assign pready_out = 1'b1;
	assign pslverr_out = psel_in & penable_in & state_reg.slverr;
	assign prdata_out = state_reg.rdata;

	// Node pattern 15 still reported raw; status flags it
	assign node_address_out = node_eff;
	assign node_from_setting_out = from_setting;
	assign link_rs485_out = state_reg.boot_sw.sel_rs485;
	assign keypad_select_out = state_reg.boot_sw.keypad;
	assign autorun_suppress_out = state_reg.autorun_sup;

	assign hold_out = state_reg.smp.hold;
	assign terminator_out = state_reg.smp.term;
	assign drive_enable_out = state_reg.drive_en;

	assign offset_trim_start_out = state_reg.tune_pulse;
	assign restore_all_out = state_reg.restore_all;
	assign restore_keep_link_out = state_reg.restore_keep;

endmodule

// [dsc_decoder_properties.sv]
// Port-level checks of the switch decoder
`include "dsc_defs.svh"
`timescale 1ns/100ps
module dsc_decoder_properties #(
	parameter int unsigned SAMPLE_CYCLES = 20
) (
	// Clock, reset and inputs
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [`DSC_ADDR_W-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic ext_enable_in,
	// Decoder outputs
	input wire logic [3:0] node_address_out,
	input wire logic node_from_setting_out,
	input wire logic link_rs485_out,
	input wire logic keypad_select_out,
	input wire logic autorun_suppress_out,
	input wire logic hold_out,
	input wire logic terminator_out,
	input wire logic drive_enable_out,
	input wire logic offset_trim_start_out,
	input wire logic restore_all_out,
	input wire logic restore_keep_link_out
);
	logic cmd_wr;
	logic [3:0] since_reg;
	default clocking dcb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);
	assign cmd_wr = psel_in && penable_in && pwrite_in && paddr_in == `DSC_OFS_CMD;
	// Edges since reset or relatch; startup outputs may only move early on
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			since_reg <= 4'h0;
		end else if (cmd_wr && pwdata_in[`DSC_CMD_RELATCH_BIT]) begin
			since_reg <= 4'h0;
		end else if (since_reg != 4'hf) begin
			since_reg <= since_reg + 4'h1;
		end
	end
	node_valid_a: assert property (!node_from_setting_out |-> node_address_out != 4'h0)
		else $error("switch node is zero");
	latch_hold_a: assert property ($changed({link_rs485_out, keypad_select_out,
		autorun_suppress_out, node_from_setting_out}) |-> since_reg < 4'hc)
		else $error("startup output moved after latch");
	run_sample_a: assert property ($changed({hold_out, terminator_out})
		|=> ($stable({hold_out, terminator_out}) || since_reg < 4'hc)[*8])
		else $error("run-time output moved between samples");
	ext_gate_a: assert property (!ext_enable_in [*6] |-> !drive_enable_out)
		else $error("drive enabled without enable input");
	trim_pulse_a: assert property (offset_trim_start_out |=> !offset_trim_start_out)
		else $error("trim strobe longer than one cycle");
	trim_cmd_a: assert property (cmd_wr && pwdata_in[`DSC_CMD_TRIM_BIT] |=> offset_trim_start_out)
		else $error("trim command gave no strobe");
	soft_restore_a: assert property (cmd_wr && pwdata_in[`DSC_CMD_RESTORE_BIT]
		|=> restore_keep_link_out)
		else $error("restore command gave no strobe");
	factory_boot_a: assert property (restore_all_out |-> since_reg < 4'hc)
		else $error("factory restore outside startup");
	autorun_key_a: assert property (autorun_suppress_out |-> keypad_select_out)
		else $error("suppression without switch 9");
	trim_seen_c: cover property (offset_trim_start_out);
	factory_seen_c: cover property (restore_all_out);
	drive_on_c: cover property ($rose(drive_enable_out));
endmodule

// [dsc_switch_model.sv]
// Operator switch block and external enable line
`timescale 1ns/100ps
module dsc_switch_model (
	// Clock
	input wire logic clk_in,
	// Lever positions, high means On
	output logic [9:0] config_switch_block_out,
	output logic ext_enable_out
);
	initial begin
		config_switch_block_out = 10'h000;
		ext_enable_out = 1'b0;
	end
	// Node levers all On only when a test asks for it
	task automatic set_sw(input logic [9:0] v);
		@(posedge clk_in);
		config_switch_block_out <= v;
	endtask
	task automatic set_ext(input logic v);
		@(posedge clk_in);
		ext_enable_out <= v;
	endtask
endmodule

// [dsc_config_decoder_tb_top.sv]
// Self-checking bench of the switch decoder
`include "dsc_defs.svh"
`timescale 1ns/100ps
module dsc_config_decoder_tb_top;
	// Short sample period keeps the run brief
	localparam int unsigned SC = 20;
	logic clk_in, rst_n_in, psel, penable, pwrite, pready, pslverr, err, ext;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [9:0] sw;
	logic [3:0] node, i;
	logic from_set, rs485, keypad, autorun, hold, term, drv, trim, r_all, r_keep;
	int bad_count = 0;
	int num_checks = 0;
	int n_trim = 0;
	int n_all = 0;
	int n_keep = 0;
	int k;
	dsc_switch_model i_dsc_switch_model (.clk_in(clk_in), .config_switch_block_out(sw),
		.ext_enable_out(ext));
	dsc_config_decoder #(.SAMPLE_CYCLES(SC)) i_dsc_config_decoder (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .config_switch_block_in(sw),
		.ext_enable_in(ext), .node_address_out(node), .node_from_setting_out(from_set),
		.link_rs485_out(rs485), .keypad_select_out(keypad), .autorun_suppress_out(autorun),
		.hold_out(hold), .terminator_out(term), .drive_enable_out(drv),
		.offset_trim_start_out(trim), .restore_all_out(r_all), .restore_keep_link_out(r_keep));
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	// Strobes are counted so none is missed
	always @(posedge clk_in) begin
		n_trim += (trim === 1'b1);
		n_all += (r_all === 1'b1);
		n_keep += (r_keep === 1'b1);
	end
	// Callers arrive at a falling edge, so registered outputs are settled
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_in);
		penable <= 1'b1;
		do begin
			@(posedge clk_in);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Outputs launched at the access edge are settled here
		@(negedge clk_in);
	endtask
	task automatic relatch(input logic [9:0] v);
		i_dsc_switch_model.set_sw(v);
		apb(1'b1, `DSC_OFS_CMD, 32'h4);
		repeat (12) @(posedge clk_in);
		@(negedge clk_in);
	endtask
	task automatic ticks(input int n);
		repeat (n * SC + 4) @(posedge clk_in);
		@(negedge clk_in);
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_in);
		bad_count++;
		test_done;
	end
	initial begin
		rst_n_in = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		i_dsc_switch_model.set_sw(10'h20a);
		repeat (5) @(posedge clk_in);
		rst_n_in <= 1'b1;
		repeat (12) @(posedge clk_in);
		@(negedge clk_in);
		chk({from_set, rs485, node}, 6'h15);
		i_dsc_switch_model.set_sw(10'h006);
		ticks(1);
		chk({rs485, node}, 5'h15);
		for (k = 1; k < 15; k++) begin
			i = k[3:0];
			relatch({6'h00, i[0], i[1], i[2], i[3]});
			chk(node, i);
		end
		$display("node tests done");
		relatch(10'h000);
		chk({from_set, node}, 5'h11);
		apb(1'b1, `DSC_OFS_CTRL, 32'h93);
		chk(node, 4'h9);
		// Unmapped place must answer with an error and zero
		apb(1'b0, 8'h10, 32'h0);
		chk({err, rd}, 33'h100000000);
		apb(1'b1, `DSC_OFS_CMD, 32'h2);
		apb(1'b0, `DSC_OFS_CTRL, 32'h0);
		chk({n_keep, rd}, {32'd1, 32'h90});
		relatch(10'h00f);
		apb(1'b0, `DSC_OFS_CTRL, 32'h0);
		chk({n_all, rd}, {32'd1, 32'h10});
		relatch(10'h08f);
		chk({n_all, 28'h0, node}, {32'd1, 32'hf});
		apb(1'b0, `DSC_OFS_STATUS, 32'h0);
		chk(rd, 32'h240f);
		apb(1'b0, `DSC_OFS_SWITCH, 32'h0);
		chk(rd, 32'h8f);
		relatch(10'h110);
		chk({autorun, keypad}, 2'b11);
		relatch(10'h190);
		chk({autorun, keypad}, 2'b01);
		$display("startup tests done");
		i_dsc_switch_model.set_sw(10'h030);
		ticks(1);
		chk({hold, term}, 2'b11);
		i_dsc_switch_model.set_sw(10'h000);
		ticks(1);
		chk({hold, term}, 2'b00);
		for (k = 0; k < 8; k++) begin
			i_dsc_switch_model.set_sw(k[0] ? 10'h080 : 10'h000);
			i_dsc_switch_model.set_ext(k[1]);
			apb(1'b1, `DSC_OFS_CTRL, {31'h8, k[2]});
			ticks(1);
			chk(drv, k == 7);
		end
		i_dsc_switch_model.set_ext(1'b0);
		apb(1'b1, `DSC_OFS_CTRL, 32'h12);
		ticks(1);
		chk(drv, 1'b0);
		i_dsc_switch_model.set_ext(1'b1);
		repeat (4) @(posedge clk_in);
		@(negedge clk_in);
		chk(drv, 1'b1);
		$display("run-time tests done");
		i_dsc_switch_model.set_sw(10'h0c0);
		ticks(1);
		i_dsc_switch_model.set_sw(10'h040);
		ticks(1);
		chk(n_trim, 1);
		i_dsc_switch_model.set_sw(10'h080);
		ticks(1);
		i_dsc_switch_model.set_sw(10'h000);
		ticks(1);
		chk(n_trim, 1);
		apb(1'b1, `DSC_OFS_CMD, 32'h1);
		// Strobe is counted at the edge after it rises
		@(negedge clk_in);
		chk(n_trim, 2);
		$display("trim tests done");
		test_done;
	end
endmodule
bind dsc_config_decoder dsc_decoder_properties #(.SAMPLE_CYCLES(SAMPLE_CYCLES))
	i_dsc_decoder_properties (
	.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
	.pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
	.ext_enable_in(ext_enable_in), .node_address_out(node_address_out),
	.node_from_setting_out(node_from_setting_out), .link_rs485_out(link_rs485_out),
	.keypad_select_out(keypad_select_out), .autorun_suppress_out(autorun_suppress_out),
	.hold_out(hold_out), .terminator_out(terminator_out), .drive_enable_out(drive_enable_out),
	.offset_trim_start_out(offset_trim_start_out), .restore_all_out(restore_all_out),
	.restore_keep_link_out(restore_keep_link_out));
